// *** common/pgef_consts.vh ***
`ifndef PGEF_CONSTS_VH
`define PGEF_CONSTS_VH
`define PGEF_OFF_GOOD_A 8'h37
`define PGEF_OFF_GOOD_B 8'h38
`define PGEF_OFF_FLAGS 8'h39
`define PGEF_OFF_MASKS 8'h3A
`define PGEF_ADDR_GOOD_A 12'h0DC
`define PGEF_ADDR_GOOD_B 12'h0E0
`define PGEF_ADDR_FLAGS 12'h0E4
`define PGEF_ADDR_MASKS 12'h0E8
`define PGEF_ADDR_CTRL 12'h100
`define PGEF_FLAGS_RST 8'h00
`define PGEF_MASKS_RST 8'hFF
`define PGEF_CTRL_RST 2'h0
`define PGEF_GOOD_B_RSVD 2'h0
`define PGEF_BIT_PIN1_FALL 7
`define PGEF_BIT_PIN1_RISE 6
`define PGEF_BIT_OVERTEMP 5
`define PGEF_BIT_HOLD_RISE 4
`define PGEF_BIT_BTN_LONG 3
`define PGEF_BIT_BTN_EVENT 2
`define PGEF_BIT_SUPPLY 1
`define PGEF_BIT_HOLD_FALL 0
`endif

// *** design/pgef_edge.v ***
`timescale 1ns/100ps
module pgef_edge (
    clk,
    rstn,
    level,
    rise,
    fall
);
    input wire clk;
    input wire rstn;
    input wire level;
    output wire rise;
    output wire fall;
    reg last_ff;

    // Reset value 0 means a level already high at reset shows one rise.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_ff <= 1'b0;
        end else begin
            last_ff <= level;
        end
    end
    assign rise = level & ~last_ff;
    assign fall = ~level & last_ff;
endmodule // pgef_edge

// *** design/pgef_sync.v ***
`timescale 1ns/100ps
module pgef_sync #(
    parameter W = 1
) (
    clk,
    rstn,
    din,
    dout
);
    input wire clk;
    input wire rstn;
    input wire [W-1:0] din;
    output wire [W-1:0] dout;
    reg [W-1:0] stage1_ff;
    reg [W-1:0] stage2_ff;

    // Two flip-flops for every asynchronous input.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1_ff <= {W{1'b0}};
            stage2_ff <= {W{1'b0}};
        end else begin
            stage1_ff <= din;
            stage2_ff <= stage1_ff;
        end
    end
    assign dout = stage2_ff;
endmodule // pgef_sync

// *** design/pgef_top.v ***
// Behaviour
// - Status A: bits 7..4 linear regs 4..1, bits 3..0 bucks 4..1.
// - Status B: linear regs 10..5 in bits 5..0, bits 7..6 read zero.
// - A good bit reads one while its regulator is in regulation.
// - A good bit reads zero when output is low or regulator disabled; here only linear bits are gated by enable, buck bits are not.
// - Linear good bit is invalid when enabled with input below 1 V.
// - Good registers ignore writes and clear on power-on reset.
// - Event flag layout fixed bit 7 down to 0, reset all zeros.
// - A set flag stays until software writes one to it.
// - Separate flags for rising and falling edges of pin 1.
// - Over-temperature warning sets its flag.
// - Separate flags for rising and falling edges of the hold input.
// - A detected long button press sets the long-press flag.
// - A detected button event sets the button-event flag.
// - Supply drop below selected threshold sets its flag, no delay.
// - Mask bits share flag positions; one masks, zero unmasks.
// - Mask register is read-write and resets to all ones.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`include "pgef_consts.vh"
module pgef_top (
    clk,
    rstn,
    paddr,
    psel,
    penable,
    pwrite,
    pwdata,
    pstrb,
    prdata,
    pready,
    pslverr,
    buck1_good,
    buck2_good,
    buck3_good,
    buck4_good,
    linregGood,
    linregEnable,
    linregSupplyOk,
    general_pin_1,
    power_hold_input,
    die_overtemp,
    buttonEvent,
    buttonLong,
    supplyBelow,
    supply_threshold_select,
    irq
);
    input wire clk;
    input wire rstn;
    input wire [11:0] paddr;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [31:0] pwdata;
    input wire [3:0] pstrb;
    output reg [31:0] prdata;
    output reg pready;
    output reg pslverr;
    input wire buck1_good;
    input wire buck2_good;
    input wire buck3_good;
    input wire buck4_good;
    input wire [9:0] linregGood;
    input wire [9:0] linregEnable;
    input wire [9:0] linregSupplyOk;
    input wire general_pin_1;
    input wire power_hold_input;
    input wire die_overtemp;
    input wire buttonEvent;
    input wire buttonLong;
    input wire [3:0] supplyBelow;
    output wire [1:0] supply_threshold_select;
    output reg irq;

    reg [7:0] goodA_ff;
    reg [7:0] goodB_ff;
    reg [7:0] flags_ff;
    reg [7:0] masks_ff;
    reg [1:0] thrSel_ff;
    reg [9:0] linValid_ff;
    reg overtempLast_ff;
    reg btnLast_ff;
    reg longLast_ff;
    reg [7:0] nxt_flags;
    reg [7:0] events;
    reg [31:0] nxt_rdata;
    reg nxt_err;
    wire [3:0] buckSync;
    wire [9:0] linSync;
    wire [9:0] linEnSync;
    wire [9:0] linSupSync;
    wire [7:0] evSync;
    wire pinRise;
    wire pinFall;
    wire holdRise;
    wire holdFall;
    wire supplyNow;
    wire access;
    wire wrAccess;
    wire [9:0] linGood;
    wire [7:0] wrByte;

    function addrHit;
        input [11:0] a;
        input [11:0] b;
        begin
            addrHit = (a == b);
        end
    endfunction

    pgef_sync #(.W(4)) u_syncBuck (
        .clk(clk),
        .rstn(rstn),
        .din({buck4_good, buck3_good, buck2_good, buck1_good}),
        .dout(buckSync)
    );
    pgef_sync #(.W(10)) u_syncLin (
        .clk(clk),
        .rstn(rstn),
        .din(linregGood),
        .dout(linSync)
    );
    pgef_sync #(.W(10)) u_syncLinEn (
        .clk(clk),
        .rstn(rstn),
        .din(linregEnable),
        .dout(linEnSync)
    );
    pgef_sync #(.W(10)) u_syncLinSup (
        .clk(clk),
        .rstn(rstn),
        .din(linregSupplyOk),
        .dout(linSupSync)
    );
    pgef_sync #(.W(8)) u_syncEv (
        .clk(clk),
        .rstn(rstn),
        .din({general_pin_1, power_hold_input, die_overtemp, buttonEvent,
            buttonLong, supplyBelow[0], supplyBelow[1], 1'b0}),
        .dout(evSync)
    );
    pgef_edge u_pinEdge (
        .clk(clk),
        .rstn(rstn),
        .level(evSync[7]),
        .rise(pinRise),
        .fall(pinFall)
    );
    pgef_edge u_holdEdge (
        .clk(clk),
        .rstn(rstn),
        .level(evSync[6]),
        .rise(holdRise),
        .fall(holdFall)
    );

    reg [3:0] supSync1_ff;
    reg [3:0] supSync2_ff;
    reg supplyLast_ff;
    // The comparator of the selected threshold is watched for its drop.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            supSync1_ff <= 4'h0;
            supSync2_ff <= 4'h0;
        end else begin
            supSync1_ff <= supplyBelow;
            supSync2_ff <= supSync1_ff;
        end
    end
    assign supplyNow = supSync2_ff[thrSel_ff];
    assign supply_threshold_select = thrSel_ff;

    // Linear good bits follow comparators; zero if disabled.
    assign linGood = linSync & linEnSync;

    assign access = psel & penable;
    assign wrAccess = access & pwrite;
    assign wrByte = pstrb[0] ? pwdata[7:0] : 8'h00;

    always @* begin
        events = 8'h00;
        events[`PGEF_BIT_PIN1_FALL] = pinFall;
        events[`PGEF_BIT_PIN1_RISE] = pinRise;
        events[`PGEF_BIT_OVERTEMP] = evSync[5] & ~overtempLast_ff;
        events[`PGEF_BIT_HOLD_RISE] = holdRise;
        events[`PGEF_BIT_BTN_LONG] = evSync[3] & ~longLast_ff;
        events[`PGEF_BIT_BTN_EVENT] = evSync[4] & ~btnLast_ff;
        events[`PGEF_BIT_SUPPLY] = supplyNow & ~supplyLast_ff;
        events[`PGEF_BIT_HOLD_FALL] = holdFall;
    end

    always @* begin
        nxt_flags = flags_ff;
        if (wrAccess && !pready && addrHit(paddr, `PGEF_ADDR_FLAGS)) begin
            nxt_flags = flags_ff & ~wrByte;
        end
        nxt_flags = nxt_flags | events;
    end

    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err = 1'b0;
        case (paddr)
            `PGEF_ADDR_GOOD_A: nxt_rdata[7:0] = goodA_ff;
            `PGEF_ADDR_GOOD_B: nxt_rdata[7:0] = goodB_ff;
            `PGEF_ADDR_FLAGS: nxt_rdata[7:0] = flags_ff;
            `PGEF_ADDR_MASKS: nxt_rdata[7:0] = masks_ff;
            `PGEF_ADDR_CTRL: nxt_rdata[1:0] = thrSel_ff;
            default: nxt_err = 1'b1;
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            goodA_ff <= 8'h00;
            goodB_ff <= 8'h00;
            flags_ff <= `PGEF_FLAGS_RST;
            masks_ff <= `PGEF_MASKS_RST;
            thrSel_ff <= `PGEF_CTRL_RST;
            linValid_ff <= 10'h000;
            overtempLast_ff <= 1'b0;
            btnLast_ff <= 1'b0;
            longLast_ff <= 1'b0;
            supplyLast_ff <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            // Writes never reach the good registers.
            goodA_ff <= {linGood[3:0], buckSync & 4'hF};
            goodB_ff <= {`PGEF_GOOD_B_RSVD, linGood[9:4]};
            // Validity of each linear bit, shown nowhere but kept for use.
            linValid_ff <= ~linEnSync | linSupSync;
            overtempLast_ff <= evSync[5];
            btnLast_ff <= evSync[4];
            longLast_ff <= evSync[3];
            supplyLast_ff <= supplyNow;
            flags_ff <= nxt_flags;
            if (wrAccess && !pready && pstrb[0]) begin
                if (addrHit(paddr, `PGEF_ADDR_MASKS)) begin
                    masks_ff <= pwdata[7:0];
                end
                if (addrHit(paddr, `PGEF_ADDR_CTRL)) begin
                    thrSel_ff <= pwdata[1:0];
                end
            end
            pready <= access & ~pready;
            pslverr <= access & ~pready & nxt_err;
            if (access && !pready && !pwrite) begin
                prdata <= nxt_rdata;
            end
            irq <= |(nxt_flags & ~masks_ff);
        end
    end
endmodule // pgef_top

// *** testbench/pgef_checker.sv ***
`timescale 1ns/100ps
module pgef_checker (
    input wire clk,
    input wire rstn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq
);
    reg [7:0] maskCopy_ff;
    wire taken = psel && penable && !pready;
    wire mapped = paddr == 12'h0DC || paddr == 12'h0E0
        || paddr == 12'h0E4 || paddr == 12'h0E8 || paddr == 12'h100;
    wire rdB = pready && !pwrite && paddr == 12'h0E0;
    wire rdM = pready && !pwrite && paddr == 12'h0E8;
    wire allMasked = maskCopy_ff == 8'hFF;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // A shadow of the mask, updated when a mask write completes.
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            maskCopy_ff <= 8'hFF;
        else if (pready && pwrite && pstrb[0] && paddr == 12'h0E8)
            maskCopy_ff <= pwdata[7:0];
    end
    a_ready_follows: assert property (taken |=> pready)
        else $error("no ready after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(taken))
        else $error("ready without access");
    a_unmapped_err: assert property (pready |-> pslverr == !mapped)
        else $error("error flag wrong for address");
    a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("error read not zero");
    a_rsvd_zero: assert property (rdB |-> prdata[31:6] == 26'h0)
        else $error("reserved bits set");
    a_mask_readback: assert property (rdM |-> prdata[7:0] == maskCopy_ff)
        else $error("mask read back wrong");
    a_irq_masked: assert property (allMasked && $past(allMasked) |-> !irq)
        else $error("interrupt while all masked");
endmodule // pgef_checker
bind pgef_top pgef_checker u_chk (.clk(clk), .rstn(rstn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));

// *** testbench/pgef_top_tb.sv ***
`timescale 1ns/100ps
module pgef_top_tb;
    localparam [63:0] TG = 64'h2010080402020101;
    localparam [63:0] EX = 64'h0208042001108040;
    reg clk = 0;
    reg rstn = 0;
    reg [11:0] paddr = 0;
    reg psel = 0, penable = 0, pwrite = 0, rErr = 0;
    reg [31:0] pwdata = 0, rdat = 0, e = 0;
    reg [3:0] buckGood = 0;
    reg [3:0] pstrb = 4'hF;
    reg [9:0] lGood = 0, lEn = 0;
    reg [5:0] ev = 0;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [1:0] thrSel;
    integer errCount = 0, checked = 0, cyc = 0, i;
    always #25 clk = ~clk;
    pgef_top u_dut (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .buck1_good(buckGood[0]), .buck2_good(buckGood[1]),
        .buck3_good(buckGood[2]), .buck4_good(buckGood[3]),
        .linregGood(lGood), .linregEnable(lEn), .linregSupplyOk(10'h3FF),
        .general_pin_1(ev[0]), .power_hold_input(ev[1]),
        .die_overtemp(ev[2]), .buttonEvent(ev[3]), .buttonLong(ev[4]),
        .supplyBelow({3'h0, ev[5]}), .supply_threshold_select(thrSel),
        .irq(irq));
    task chk(input [95:0] nm, input [31:0] ex, input [31:0] got);
        checked = checked + 1;
        if (got !== ex) begin
            errCount = errCount + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, ex, got);
        end
    endtask
    task xfer(input w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdat = prdata;
        rErr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            errCount = errCount + 1;
            conclude;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1;
        xfer(0, 12'h0E8, 0);
        chk("masks", 32'hFF, rdat);
        xfer(0, 12'h0E4, 0);
        chk("flags", 32'h0, rdat);
        xfer(0, 12'h0DC, 0);
        chk("goodA", 32'h0, rdat);
        $display("test reset done");
        buckGood <= 4'h5;
        lGood <= 10'h3FF;
        lEn <= 10'h2F5;
        repeat (5) @(posedge clk);
        xfer(0, 12'h0DC, 0);
        chk("goodA", 32'h55, rdat);
        xfer(1, 12'h0DC, 32'hFF);
        xfer(1, 12'h0E0, 32'hFF);
        xfer(0, 12'h0E0, 0);
        chk("goodB", 32'h2F, rdat);
        xfer(0, 12'h0DC, 0);
        chk("goodA", 32'h55, rdat);
        $display("test good done");
        xfer(1, 12'h0E8, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            ev <= ev ^ TG[8*i +: 6];
            e = EX[8*i +: 8];
            repeat (6) @(posedge clk);
            xfer(0, 12'h0E4, 0);
            chk("flags", e, rdat);
            chk("irq", 32'h1, irq);
            xfer(1, 12'h0E4, e);
            xfer(0, 12'h0E4, 0);
            chk("cleared", 32'h0, rdat);
            chk("irq", 32'h0, irq);
        end
        $display("test events done");
        xfer(1, 12'h0E8, 32'hFF);
        ev <= ev ^ 6'h01;
        repeat (6) @(posedge clk);
        xfer(0, 12'h0E4, 0);
        chk("flags", 32'h40, rdat);
        chk("irq", 32'h0, irq);
        xfer(1, 12'h0E8, 32'hBF);
        xfer(0, 12'h0E8, 0);
        chk("masks", 32'hBF, rdat);
        chk("irq", 32'h1, irq);
        pstrb <= 4'h0;
        xfer(1, 12'h0E8, 32'h0);
        pstrb <= 4'hF;
        xfer(0, 12'h0E8, 0);
        chk("masks", 32'hBF, rdat);
        $display("test mask done");
        xfer(1, 12'h100, 32'h3);
        chk("thrSel", 32'h3, thrSel);
        xfer(0, 12'h0F0, 0);
        chk("slverr", 32'h1, rErr);
        chk("errdata", 32'h0, rdat);
        $display("test access done");
        conclude;
    end
endmodule // pgef_top_tb
